// >>> hdl/sapr_pkg.sv
// constants, field layout and types of the sleep and power reduction controller
package sapr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and bus
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned ADDR_W        = 8;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] MCU_CONTROL_IDX   = 8'h35;
  localparam logic [7:0] PERIPH_GATE_IDX   = 8'h36;
  localparam logic [7:0] SLEEP_STATUS_IDX  = 8'h37;
  localparam logic [7:0] BROWNOUT_CTRL_IDX = 8'h07;
  localparam logic [ADDR_W-1:0] MCU_CONTROL_ADDR   = {MCU_CONTROL_IDX[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] PERIPH_GATE_ADDR   = {PERIPH_GATE_IDX[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] SLEEP_STATUS_ADDR  = {SLEEP_STATUS_IDX[5:0], 2'h0};
  localparam logic [ADDR_W-1:0] BROWNOUT_CTRL_ADDR = {BROWNOUT_CTRL_IDX[5:0], 2'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int unsigned PULLUP_OFF_BIT     = 7;
  localparam int unsigned SM_HI_BIT          = 6;
  localparam int unsigned ARM_BIT            = 5;
  localparam int unsigned SM_LO_BIT          = 4;
  localparam int unsigned BROWNOUT_OFF_BIT   = 1;
  localparam int unsigned BROWNOUT_UNLCK_BIT = 0;
  localparam logic [7:0]  MCU_CONTROL_RST    = 8'h00;
  localparam logic [7:0]  PERIPH_GATE_RST    = 8'h00;
  localparam logic [1:0]  SM_IDLE_CODE       = 2'h0;
  localparam logic [1:0]  SM_STANDBY_CODE    = 2'h2;
  localparam int unsigned GATE_COUNT         = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // cycle counts
  localparam int unsigned DELAY_W                = 16;
  localparam logic [2:0]  UNLOCK_WINDOW_CYCLES   = 3'h4;
  localparam logic [2:0]  SLEEP_OFF_DELAY_CYCLES = 3'h3;
  localparam logic [2:0]  SLEEP_OFF_HOLD_CYCLES  = 3'h3;
  localparam logic [DELAY_W-1:0] IDLE_WAKE_CYCLES    = 16'h0001;
  localparam logic [DELAY_W-1:0] STANDBY_WAKE_CYCLES = 16'h0006;
  localparam logic [DELAY_W-1:0] IRQ_HALT_CYCLES     = 16'h0004;
  localparam int unsigned PD_WAKE_CYCLES_DEF  = 16;
  localparam int unsigned BOD_WAKE_TIME_NS    = 60000;
  localparam int unsigned BOD_WAKE_CYCLES_DEF =
    (BOD_WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0, ST_SLEEP = 2'h1, ST_START = 2'h3, ST_HALT = 2'h2
  } sapr_state_type;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0, MODE_PDOWN = 2'h1, MODE_STANDBY = 2'h2
  } sapr_mode_type;

  function automatic logic saprIsDeep(input sapr_mode_type m);
    return m != MODE_IDLE;
  endfunction : saprIsDeep

endpackage : sapr_pkg

// >>> hdl/sapr_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sapr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1Q <= '0;
      syncOut <= '0;
    end else begin
      stage1Q <= asyncIn;
      syncOut <= stage1Q;
    end
  end
endmodule : sapr_sync
`default_nettype wire

// >>> hdl/sapr_delay.sv
// loadable down counter; done marks the last cycle of the loaded span
`timescale 1ns/1ps
`default_nettype none
module sapr_delay #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  done
);
  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
  logic [WIDTH-1:0] cntQ;

  // a load of n keeps the caller in its state for exactly n cycles
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cntQ <= '0;
    end else if (load) begin
      cntQ <= loadValue;
    end else if (cntQ != '0) begin
      cntQ <= cntQ - ONE;
    end
  end

  assign done = (cntQ == ONE);
endmodule : sapr_delay
`default_nettype wire

// >>> hdl/sapr_ctrl.sv
// sleep mode sequencing, brownout sleep-off sequence and peripheral clock gating
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - select 00 enters idle: core, flash clocks stop
// - idle wakes on external and internal interrupts
// - select 01/11: power-down, oscillator and clocks stopped
// - power-down wakes on resets, levels, pin change
// - select 10 with crystal: standby, oscillator runs
// - standby wake-up takes six cycles
// - sleep-off cuts brownout on entry, restores on wake
// - brownout off stretches wake-up to 60 us
// - sleep-off bit controls brownout in deep modes
// - sleep-off bit writable only through unlock sequence
// - unlock, set within four, active three cycles
// - gated peripheral frozen, its registers blocked
// - ungating resumes peripheral in prior state
// - gating acts in active and idle only
// - comparator disabled in deep sleep modes
// - reference on only for brownout or comparator
// - fused brownout stays on unless sleep-off applies
// - enabled watchdog runs in every sleep mode
// - input buffers off while io clock stops
// - control register: select hi 6, arm 5, lo 4
// - sleep entered only with arm bit set
// - gate bits 7..4 read zero, bit 3 timer1
// - interrupt wake halts core four extra cycles
module sapr_ctrl #(
  parameter int unsigned PD_WAKE_CYCLES  = sapr_pkg::PD_WAKE_CYCLES_DEF,
  parameter int unsigned BOD_WAKE_CYCLES = sapr_pkg::BOD_WAKE_CYCLES_DEF,
  parameter int unsigned GATES           = sapr_pkg::GATE_COUNT
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [sapr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [sapr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        sleepExec,
  input  wire logic [1:0]                  extIrqLevelPin,
  input  wire logic                        pinChangePin,
  input  wire logic                        usiStartPin,
  input  wire logic                        wdtIrq,
  input  wire logic                        ioIrq,
  input  wire logic                        extResetPin,
  input  wire logic                        wdtResetReq,
  input  wire logic                        brownoutResetReq,
  input  wire logic                        brownoutThresholdFuse,
  input  wire logic                        crystalClockSel,
  input  wire logic                        comparatorPowerOff,
  input  wire logic                        comparatorUsesRef,
  input  wire logic                        wdtEnable,
  output logic                             cpuClkEn,
  output logic                             flashClkEn,
  output logic                             ioClkEn,
  output logic                             mainOscEn,
  output logic [GATES-1:0]                 periphClkEn,
  output logic [GATES-1:0]                 periphAccessEn,
  output logic                             comparatorEn,
  output logic                             vrefEn,
  output logic                             brownoutDetectorEn,
  output logic                             wdtRunEn,
  output logic                             inputBufEn,
  output logic                             pullupGlobalOff,
  output logic [3:0]                       extIrqSense,
  output logic                             sleepNop,
  output logic                             irqServe,
  output logic                             resetWake
);
  import sapr_pkg::*;

  localparam logic [DELAY_W-1:0] PD_LOAD  = DELAY_W'(PD_WAKE_CYCLES);
  localparam logic [DELAY_W-1:0] BOD_LOAD = DELAY_W'(BOD_WAKE_CYCLES);

  function automatic logic regHit(input logic [ADDR_W-1:0] a);
    return a == MCU_CONTROL_ADDR || a == PERIPH_GATE_ADDR ||
           a == SLEEP_STATUS_ADDR || a == BROWNOUT_CTRL_ADDR;
  endfunction : regHit

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic [1:0] rstSyncQ;
  logic       rstN;
  logic [7:0] asyncS;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSyncQ <= 2'h0;
    end else begin
      rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
  end
  assign rstN = rstSyncQ[1];

  sapr_sync #(.WIDTH(8)) uSync (
    .clk     (ref_clk),
    .rstN    (rstN),
    .asyncIn ({extIrqLevelPin, pinChangePin, usiStartPin, wdtIrq,
               extResetPin, wdtResetReq, brownoutResetReq}),
    .syncOut (asyncS)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave; one write and one read in flight
  logic             awHeldQ, wHeldQ, bvalidQ, rvalidQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0]      wDataQ, rdataQ;
  logic             wLane0Q;
  logic [1:0]       brespQ, rrespQ;
  logic             doWrite, doRead, wrLane;
  logic [31:0]      rdNext;

  assign s_axi_awready = !awHeldQ;
  assign s_axi_wready  = !wHeldQ;
  assign s_axi_arready = !rvalidQ;
  assign s_axi_bvalid  = bvalidQ;
  assign s_axi_bresp   = brespQ;
  assign s_axi_rvalid  = rvalidQ;
  assign s_axi_rresp   = rrespQ;
  assign s_axi_rdata   = rdataQ;
  assign doWrite = awHeldQ && wHeldQ && !bvalidQ;
  assign doRead  = s_axi_arvalid && !rvalidQ;
  assign wrLane  = doWrite && wLane0Q;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awHeldQ <= 1'b0;
      wHeldQ  <= 1'b0;
      bvalidQ <= 1'b0;
      rvalidQ <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= 32'h0;
      wLane0Q <= 1'b0;
      brespQ  <= RESP_OKAY;
      rrespQ  <= RESP_OKAY;
      rdataQ  <= 32'h0;
    end else begin
      if (s_axi_awvalid && !awHeldQ) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeldQ <= 1'b0;
      end
      if (s_axi_wvalid && !wHeldQ) begin
        wHeldQ  <= 1'b1;
        wDataQ  <= s_axi_wdata;
        wLane0Q <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeldQ <= 1'b0;
      end
      if (doWrite) begin
        bvalidQ <= 1'b1;
        brespQ  <= regHit(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalidQ <= 1'b0;
      end
      if (doRead) begin
        rvalidQ <= 1'b1;
        rdataQ  <= rdNext;
        rrespQ  <= regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalidQ <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and brownout sleep-off sequence
  logic [7:0]       mcuControlQ;
  logic [GATES-1:0] gateQ;
  logic [2:0]       unlockCntQ, armCntQ, activeCntQ;
  logic             wrMcu, wrGate, wrBod, unlockLoad, armStart, sleepOffActive;
  logic             armBit;
  logic [1:0]       smSel;

  assign wrMcu      = wrLane && awAddrQ == MCU_CONTROL_ADDR;
  assign wrGate     = wrLane && awAddrQ == PERIPH_GATE_ADDR;
  assign wrBod      = wrLane && awAddrQ == BROWNOUT_CTRL_ADDR;
  assign unlockLoad = wrBod && wDataQ[BROWNOUT_OFF_BIT] && wDataQ[BROWNOUT_UNLCK_BIT];
  // rewriting while pending or active neither extends nor restarts it
  assign armStart = wrBod && wDataQ[BROWNOUT_OFF_BIT] && !wDataQ[BROWNOUT_UNLCK_BIT] &&
                    unlockCntQ != 3'h0 && armCntQ == 3'h0 && activeCntQ == 3'h0;
  assign sleepOffActive = activeCntQ != 3'h0;
  assign armBit  = mcuControlQ[ARM_BIT];
  assign smSel   = {mcuControlQ[SM_HI_BIT], mcuControlQ[SM_LO_BIT]};

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      mcuControlQ <= MCU_CONTROL_RST;
      gateQ       <= PERIPH_GATE_RST[GATES-1:0];
      unlockCntQ  <= 3'h0;
      armCntQ     <= 3'h0;
      activeCntQ  <= 3'h0;
    end else begin
      if (wrMcu) mcuControlQ <= wDataQ[7:0];
      if (wrGate) gateQ <= wDataQ[GATES-1:0];
      if (unlockLoad) begin
        unlockCntQ <= UNLOCK_WINDOW_CYCLES;
      end else if (unlockCntQ != 3'h0) begin
        unlockCntQ <= unlockCntQ - 3'h1;
      end
      if (armStart) begin
        armCntQ <= SLEEP_OFF_DELAY_CYCLES - 3'h1;
      end else if (armCntQ != 3'h0) begin
        armCntQ <= armCntQ - 3'h1;
      end
      if (armCntQ == 3'h1) begin
        activeCntQ <= SLEEP_OFF_HOLD_CYCLES;
      end else if (activeCntQ != 3'h0) begin
        activeCntQ <= activeCntQ - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sleep state machine
  sapr_state_type    stateQ, stateD;
  sapr_mode_type     modeQ, effMode;
  logic              bodOffQ, wakeByResetQ, sleepNopQ, irqServeQ, resetWakeQ, wdtRunQ;
  logic              wakeReset, wakeDeep, wakeNow, delayDone;
  logic              goSleep, goStart, startDone, goHalt, goActive, deepHold;
  logic [DELAY_W-1:0] modeLoad, startLoad;

  assign effMode = (smSel == SM_IDLE_CODE) ? MODE_IDLE :
                   (smSel == SM_STANDBY_CODE && crystalClockSel) ? MODE_STANDBY :
                   MODE_PDOWN;
  assign wakeReset = |asyncS[2:0];
  assign wakeDeep  = |asyncS[7:3];
  assign wakeNow   = wakeReset || wakeDeep || (!saprIsDeep(modeQ) && ioIrq);
  assign goSleep   = stateQ == ST_ACTIVE && sleepExec && armBit;
  assign goStart   = stateQ == ST_SLEEP && wakeNow;
  assign startDone = stateQ == ST_START && delayDone;
  assign goHalt    = startDone && !wakeByResetQ;
  assign goActive  = (startDone && wakeByResetQ) || (stateQ == ST_HALT && delayDone);
  assign modeLoad  = (modeQ == MODE_STANDBY) ? STANDBY_WAKE_CYCLES :
                     (modeQ == MODE_PDOWN) ? PD_LOAD : IDLE_WAKE_CYCLES;
  // brownout needs its settling time before code runs again
  assign startLoad = (bodOffQ && BOD_LOAD > modeLoad) ? BOD_LOAD : modeLoad;

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ST_ACTIVE: if (goSleep) stateD = ST_SLEEP;
      ST_SLEEP:  if (goStart) stateD = ST_START;
      ST_START:  if (startDone) stateD = wakeByResetQ ? ST_ACTIVE : ST_HALT;
      ST_HALT:   if (delayDone) stateD = ST_ACTIVE;
    endcase
  end

  sapr_delay #(.WIDTH(DELAY_W)) uDelay (
    .clk       (ref_clk),
    .rstN      (rstN),
    .load      (goStart || goHalt),
    .loadValue (goHalt ? IRQ_HALT_CYCLES : startLoad),
    .done      (delayDone)
  );

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stateQ       <= ST_ACTIVE;
      modeQ        <= MODE_IDLE;
      bodOffQ      <= 1'b0;
      wakeByResetQ <= 1'b0;
      sleepNopQ    <= 1'b0;
      irqServeQ    <= 1'b0;
      resetWakeQ   <= 1'b0;
      wdtRunQ      <= 1'b0;
    end else begin
      stateQ     <= stateD;
      sleepNopQ  <= stateQ == ST_ACTIVE && sleepExec && !armBit;
      irqServeQ  <= goActive && !wakeByResetQ;
      resetWakeQ <= goActive && wakeByResetQ;
      wdtRunQ    <= wdtEnable;
      if (goSleep) begin
        modeQ   <= effMode;
        bodOffQ <= saprIsDeep(effMode) && sleepOffActive && brownoutThresholdFuse;
      end else if (goStart) begin
        bodOffQ <= 1'b0;
      end
      if (goStart) wakeByResetQ <= wakeReset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock, oscillator and analog enables
  // deep modes keep io clocks stopped until the start-up delay ends
  assign deepHold   = saprIsDeep(modeQ) && (stateQ == ST_SLEEP || stateQ == ST_START);
  assign cpuClkEn   = stateQ == ST_ACTIVE;
  assign flashClkEn = stateQ == ST_ACTIVE;
  assign ioClkEn    = !deepHold;
  assign mainOscEn  = !(stateQ == ST_SLEEP && modeQ == MODE_PDOWN);
  assign periphClkEn    = {GATES{ioClkEn}} & ~gateQ;
  assign periphAccessEn = ~gateQ;
  assign comparatorEn   = !comparatorPowerOff && !deepHold;
  assign brownoutDetectorEn = brownoutThresholdFuse && !bodOffQ;
  assign vrefEn     = brownoutDetectorEn || (comparatorUsesRef && !comparatorPowerOff);
  assign inputBufEn = ioClkEn;
  assign wdtRunEn   = wdtRunQ;
  assign pullupGlobalOff = mcuControlQ[PULLUP_OFF_BIT];
  assign extIrqSense     = mcuControlQ[3:0];
  assign sleepNop  = sleepNopQ;
  assign irqServe  = irqServeQ;
  assign resetWake = resetWakeQ;

  assign rdNext = (s_axi_araddr == MCU_CONTROL_ADDR) ? {24'h0, mcuControlQ} :
                  (s_axi_araddr == PERIPH_GATE_ADDR) ? {{(32-GATES){1'b0}}, gateQ} :
                  (s_axi_araddr == BROWNOUT_CTRL_ADDR) ?
                    {30'h0, armCntQ != 3'h0 || sleepOffActive, unlockCntQ != 3'h0} :
                  (s_axi_araddr == SLEEP_STATUS_ADDR) ?
                    {26'h0, bodOffQ, mainOscEn, modeQ, stateQ} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] startCntQ;
  logic        bodExtQ;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      startCntQ <= 16'h0;
      bodExtQ   <= 1'b0;
    end else begin
      if (goStart) bodExtQ <= bodOffQ;
      if (goStart) startCntQ <= 16'h1;
      else if (stateQ == ST_START && startCntQ != 16'hffff) startCntQ <= startCntQ + 16'h1;
    end
  end

  default clocking saprCb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  idle_clocks_a: assert property (stateQ == ST_SLEEP && modeQ == MODE_IDLE |->
    !cpuClkEn && !flashClkEn && ioClkEn && mainOscEn) else $error("idle clocks wrong");
  idle_wake_a: assert property (stateQ == ST_SLEEP && modeQ == MODE_IDLE && ioIrq
    |=> stateQ == ST_START) else $error("idle missed interrupt wake");
  pdown_clocks_a: assert property (stateQ == ST_SLEEP && modeQ == MODE_PDOWN |->
    !ioClkEn && !mainOscEn && !cpuClkEn) else $error("power-down clocks running");
  deep_nowake_a: assert property (stateQ == ST_SLEEP && saprIsDeep(modeQ) &&
    !wakeReset && !wakeDeep |=> stateQ == ST_SLEEP) else $error("deep sleep woke wrongly");
  standby_osc_a: assert property (stateQ == ST_SLEEP && modeQ == MODE_STANDBY |->
    mainOscEn && !ioClkEn) else $error("standby oscillator stopped");
  standby_wake_a: assert property (goStart && modeQ == MODE_STANDBY && !bodOffQ
    |=> (stateQ == ST_START) [*6] ##1 stateQ != ST_START) else $error("standby wake not 6");
  bod_cut_a: assert property (goSleep && saprIsDeep(effMode) && sleepOffActive &&
    brownoutThresholdFuse |=> !brownoutDetectorEn ##0 !vrefEn || comparatorUsesRef)
    else $error("brownout not cut");
  bod_restore_a: assert property (goStart |=>
    brownoutDetectorEn == $past(brownoutThresholdFuse)) else $error("brownout not restored");
  bod_delay_a: assert property (startDone && bodExtQ |->
    {16'h0, startCntQ} >= BOD_WAKE_CYCLES) else $error("brownout wake delay short");
  sleepoff_time_a: assert property (armStart |->
    ##3 sleepOffActive [*3] ##1 !sleepOffActive) else $error("sleep-off timing wrong");
  gate_block_a: assert property (!(|(periphClkEn & gateQ)))
    else $error("gated peripheral clocked");
  deep_gate_a: assert property (deepHold |-> periphClkEn == '0 && !comparatorEn)
    else $error("peripheral clock in deep sleep");
  wdt_run_a: assert property (wdtEnable |=> wdtRunEn)
    else $error("watchdog stopped");
  nop_sleep_a: assert property (stateQ == ST_ACTIVE && sleepExec && !armBit
    |=> stateQ == ST_ACTIVE && sleepNop && cpuClkEn) else $error("unarmed sleep acted");
  irq_halt_a: assert property (goHalt |=>
    (stateQ == ST_HALT && !cpuClkEn) [*4] ##1 irqServe && cpuClkEn)
    else $error("interrupt halt not four");

  idle_cycle_c: cover property (goSleep && effMode == MODE_IDLE ##[1:50] irqServe);
  standby_cycle_c: cover property (goSleep && effMode == MODE_STANDBY ##[1:50] irqServe);
  sleepoff_c: cover property (unlockLoad ##[1:4] armStart ##[1:8] goSleep && sleepOffActive);
  reset_wake_c: cover property (goStart && wakeReset ##[1:50] resetWake);
endmodule : sapr_ctrl
`default_nettype wire

// >>> sim/sapr_core_model.sv
// behavioural core that issues the sleep instruction
`timescale 1ns/1ps
`default_nettype none
module sapr_core_model (
  input  wire logic ref_clk,
  input  wire logic doSleep,
  input  wire logic cpuClkEn,
  output var  logic sleepExec
);
  initial sleepExec = 1'b0;
  // a halted core executes nothing, so no sleep while its clock is off
  always @(posedge ref_clk) sleepExec <= doSleep & cpuClkEn;
endmodule : sapr_core_model
`default_nettype wire

// >>> sim/sleep_and_power_reduction_ctrl_test.sv
// self-checking bench of the sleep and power reduction controller
`timescale 1ns/1ps
`default_nettype none
module sleep_and_power_reduction_ctrl_test;
  import sapr_pkg::*;
  logic ref_clk = 0, arst_n = 0, doSleep = 0, sleepExec, s_axi_bready = 1, s_axi_rready = 1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hf, extIrqSense, periphClkEn, periphAccessEn;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, extIrqLevelPin = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, pinChangePin = 0, ioIrq = 0;
  logic usiStartPin = 0, wdtIrq = 0, extResetPin = 0, wdtResetReq = 0, brownoutResetReq = 0;
  logic brownoutThresholdFuse = 0, crystalClockSel = 0, comparatorPowerOff = 0, wdtEnable = 0;
  logic comparatorUsesRef = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpuClkEn, flashClkEn, ioClkEn, mainOscEn, comparatorEn, vrefEn;
  logic brownoutDetectorEn, wdtRunEn, inputBufEn, pullupGlobalOff, sleepNop, irqServe, resetWake;
  int failures = 0, n_compared = 0, nNop = 0, nIrq = 0, nRst = 0, n;
  sapr_ctrl #(.PD_WAKE_CYCLES(3), .BOD_WAKE_CYCLES(20)) sapr_ctrl_i (.*);
  sapr_core_model sapr_core_model_i (.ref_clk, .doSleep, .cpuClkEn, .sleepExec);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    nNop <= nNop + int'(sleepNop === 1'b1);
    nIrq <= nIrq + int'(irqServe === 1'b1);
    nRst <= nRst + int'(resetWake === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // bready and rready stay high; callers enter just after an edge
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      // release only what is still offered, so a back-to-back call never races it
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask : axw
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
  endtask : axr
  task automatic slp();
    doSleep <= 1'b1;
    @(posedge ref_clk);
    doSleep <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : slp
  task automatic waitAwake();
    for (n = 0; cpuClkEn !== 1'b1; n++) @(posedge ref_clk);
  endtask : waitAwake
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axr(MCU_CONTROL_ADDR); chk("mcu reset", rd, 32'h0);
    axr(8'h40); chk("unmapped resp", s_axi_rresp, RESP_SLVERR);
    axw(MCU_CONTROL_ADDR, 8'h8f); chk("mcu bresp", s_axi_bresp, RESP_OKAY);
    #1 chk("mcu fields", {pullupGlobalOff, extIrqSense}, 5'h1f);
    s_axi_wstrb <= 4'he; axw(MCU_CONTROL_ADDR, 8'h00); s_axi_wstrb <= 4'hf;
    #1 chk("lane0 off", pullupGlobalOff, 1'b1);
    axw(8'h40, 8'h00); chk("unmapped bresp", s_axi_bresp, RESP_SLVERR);
    axw(PERIPH_GATE_ADDR, 8'hff); axr(PERIPH_GATE_ADDR); chk("gate read", rd, 32'hf);
    #1 chk("gated access", periphAccessEn, 4'h0);
    axw(PERIPH_GATE_ADDR, 8'h08); #1 chk("timer1 gate", periphClkEn, 4'h7);
    axw(PERIPH_GATE_ADDR, 8'h00); #1 chk("ungated", periphClkEn, 4'hf);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_idle();
    axw(MCU_CONTROL_ADDR, 8'h00); slp(); chk("nop", nNop, 1);
    chk("nop clock", cpuClkEn, 1'b1);
    axw(MCU_CONTROL_ADDR, 8'h20); slp(); chk("idle cpu", {cpuClkEn, flashClkEn}, 2'h0);
    chk("idle io osc cmp", {ioClkEn, mainOscEn, comparatorEn}, 3'h7);
    ioIrq <= 1'b1; waitAwake(); ioIrq <= 1'b0;
    // wake-detect cycle plus one: the edge sample lags the state by a cycle
    chk("halt span", n, 2 + IDLE_WAKE_CYCLES + IRQ_HALT_CYCLES);
    #1 chk("irq serve", nIrq, 1);
    $display("t_idle done");
  endtask : t_idle
  task automatic t_pdown();
    wdtEnable <= 1'b1; brownoutThresholdFuse <= 1'b1;
    axw(MCU_CONTROL_ADDR, 8'h30); slp(); chk("pd clocks", {mainOscEn, ioClkEn, inputBufEn}, 0);
    chk("pd cmp", comparatorEn, 1'b0); chk("pd wdt", wdtRunEn, 1'b1);
    chk("pd bod vref", {brownoutDetectorEn, vrefEn}, 2'h3);
    ioIrq <= 1'b1; repeat (8) @(posedge ref_clk); ioIrq <= 1'b0;
    #1 chk("pd no io wake", cpuClkEn, 1'b0);
    extIrqLevelPin <= 2'h1; waitAwake(); extIrqLevelPin <= 2'h0;
    #1 chk("pd level wake", nIrq, 2);
    $display("t_pdown done");
  endtask : t_pdown
  task automatic t_standby();
    crystalClockSel <= 1'b1;
    axw(MCU_CONTROL_ADDR, 8'h60);
    axw(BROWNOUT_CTRL_ADDR, 8'h03); axw(BROWNOUT_CTRL_ADDR, 8'h02); slp();
    chk("sb osc io", {mainOscEn, ioClkEn}, 2'h2);
    chk("sb bod off", brownoutDetectorEn, 1'b0);
    axr(SLEEP_STATUS_ADDR); chk("sb status", rd, 32'h39);
    wdtResetReq <= 1'b1; waitAwake(); wdtResetReq <= 1'b0;
    chk("bod wake span", n > 20, 1'b1);
    #1 chk("bod back", brownoutDetectorEn, 1'b1); chk("rst wake", nRst, 1);
    $display("t_standby done");
  endtask : t_standby
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs(); t_idle(); t_pdown(); t_standby();
    tally_and_finish();
  end
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
endmodule : sleep_and_power_reduction_ctrl_test
`default_nettype wire
